// ===== shared/dcr_pkg.sv
// package: constants and types for the disc controller register bank
package dcr_pkg;
  // accumulator bit positions use left-to-right numbering: bit 0 is the msb
  localparam int ACC_W = 16;
  // data-out a fields
  localparam int CMD_MSB = 5;
  localparam int CMD_W = 4;
  localparam int DRV_MSB = 9;
  localparam int DRV_W = 2;
  localparam int VOL_BIT = 11;
  localparam int AUX_MSB = 12;
  localparam int AUX_W = 4;
  // data-out c fields
  localparam int CYL_MSB = 6;
  localparam int CYL_W = 10;
  localparam int SURF_MSB = 1;
  localparam int SURF_W = 5;
  localparam int SECT_MSB = 6;
  localparam int SECT_W = 5;
  localparam int CNT_MSB = 11;
  localparam int CNT_W = 5;
  // data-in b alternate 1 field
  localparam int XMA_MSB = 12;
  // status and ecc widths
  localparam int CSTAT_W = 15;
  localparam int DSTAT_W = 10;
  localparam int ECC_W = 32;
  localparam int DEVCODE_W = 6;
  localparam logic [5:0] DEVCODE_RST = 6'h17;
  localparam logic [3:0] CMD_SEEK_RST = 4'h2;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    DCR_MODE_NORMAL = 2'b00,
    DCR_MODE_ALT1 = 2'b01,
    DCR_MODE_ALT2 = 2'b10
  } dcr_mode_type;

  typedef enum logic [2:0] {
    DCR_OP_NONE = 3'b000,
    DCR_OP_DOA = 3'b001,
    DCR_OP_DOB = 3'b010,
    DCR_OP_DOC = 3'b011,
    DCR_OP_DIA = 3'b100,
    DCR_OP_DIB = 3'b101,
    DCR_OP_DIC = 3'b110
  } dcr_op_type;

  typedef struct packed {
    logic strobe;
    dcr_op_type op;
    logic [5:0] devcode;
    logic [15:0] acc;
  } dcr_req_type;

  typedef struct packed {
    logic [ECC_W-1:0] ecc;
    logic [CSTAT_W-1:0] cstat;
    logic [DSTAT_W-1:0] dstat;
  } dcr_status_type;
endpackage

// ===== hw/dcr_field.sv
// module: extracts and places fields in big-endian numbered accumulator words
`timescale 1ns/1ps
module dcr_field #(
  parameter int MSB = 0,
  parameter int W = 1
) (
  input wire logic [15:0] word,
  input wire logic [W-1:0] value,
  output logic [W-1:0] field,
  output logic [15:0] placed
);
  // bit n of the accumulator is vector bit 15-n
  assign field = word[15-MSB -: W];
  always_comb begin
    placed = 16'h0000;
    placed[15-MSB -: W] = value;
  end
endmodule

// ===== hw/dcr_regs.sv
// module: programmer-visible register bank of the disc controller
`timescale 1ns/1ps
// Notes on behaviour
// - data_out_a loads 4-bit command from accumulator bits 5-8.
// - all sixteen command codes 0000 to 1111 are decoded.
// - data_out_a loads 2-bit drive select from bits 9-10.
// - data_out_b loads full 16-bit memory pointer.
// - data_in_a in alternate 1 returns memory pointer.
// - data_out_c loads cylinder from bits 6-15 after a seek command.
// - data_out_a captures bit 11 as volume for fixed/removable drives only.
// - data_out_c loads head from bits 1-5 after non-seek command.
// - data_in_c returns head in bits 1-5.
// - non-seek data_out_c loads sector field bits 6-10; data_in_c returns it.
// - non-seek data_out_c loads negated count bits 11-15; data_in_c returns it.
// - 32-bit ecc remainder; alternate 2 data_in_a returns upper half.
// - alternate 2 data_in_b returns lower ecc half.
// - 15 controller flags returned by data_in_a in normal mode.
// - 10 drive flags returned by data_in_b in normal mode.
// - data_out_a holds bits 12-15 as pending page bits.
// - data_out_b copies pending page bits to extended memory page.
// - alternate 1 data_in_b returns page in bits 12-15.
// - only instructions with matching 6-bit device code are acted on.
// - device code defaults to octal 27, strap changeable.
module dcr_regs
  import dcr_pkg::*;
#(
  parameter logic [3:0] SEEK_CODE = CMD_SEEK_RST
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire dcr_req_type req,
  input wire logic [5:0] devcode_strap,
  input wire logic [3:0] fixed_removable_drives,
  input wire dcr_mode_type read_mode_in,
  input wire logic read_mode_load,
  input wire dcr_status_type status_in,
  output logic [15:0] data_in_word,
  output logic data_in_valid,
  output logic [15:0] cmd_decode,
  output logic [3:0] command_code,
  output logic [1:0] drive_select,
  output logic [15:0] host_memory_pointer,
  output logic [3:0] extended_memory_page,
  output logic [9:0] cylinder_number,
  output logic volume_select,
  output logic [4:0] head_number,
  output logic [4:0] sector_number,
  output logic [4:0] sector_count_neg,
  output logic [15:0] aux_dbg
);
  // ==========================================================
  // strap capture and request qualification
  logic [5:0] devcode_q;
  logic strap_done_q;
  logic hit;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      devcode_q <= DEVCODE_RST;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      // strap is sampled once after reset release; it is static board wiring
      devcode_q <= devcode_strap;
      strap_done_q <= 1'b1;
    end
  end
  assign hit = req.strobe && (req.devcode == devcode_q);

  // ==========================================================
  // pin synchronisers for drive strapping and status lines
  // a bit is taken only once stages two and three agree, so a
  // one-cycle glitch in stage two never reaches the read words
  localparam int PIN_W = ECC_W + CSTAT_W + DSTAT_W + 4;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_q;
  dcr_status_type stat_sync;
  logic [3:0] drives_sync;
  assign pin_raw = {status_in, fixed_removable_drives};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= {PIN_W{1'b0}};
      pin_s2_q <= {PIN_W{1'b0}};
      pin_s3_q <= {PIN_W{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_q[gi] <= 1'b0;
      end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
        pin_q[gi] <= pin_s3_q[gi];
      end
    end
  end

  assign stat_sync = pin_q[PIN_W-1:4];
  assign drives_sync = pin_q[3:0];

  // ==========================================================
  // field extraction
  logic [3:0] f_cmd;
  logic [1:0] f_drv;
  logic [3:0] f_aux;
  logic [9:0] f_cyl;
  logic [4:0] f_surf;
  logic [4:0] f_sect;
  logic [4:0] f_cnt;
  logic [15:0] p_surf;
  logic [15:0] p_sect;
  logic [15:0] p_cnt;
  logic [15:0] p_xma;
  logic [4:0] cnt_q;
  logic [4:0] surf_q;
  logic [4:0] sect_q;
  logic [3:0] xma_q;

  dcr_field #(.MSB(CMD_MSB), .W(CMD_W)) u_cmd (.word(req.acc), .value(4'h0), .field(f_cmd), .placed());
  dcr_field #(.MSB(DRV_MSB), .W(DRV_W)) u_drv (.word(req.acc), .value(2'h0), .field(f_drv), .placed());
  dcr_field #(.MSB(AUX_MSB), .W(AUX_W)) u_aux (.word(req.acc), .value(4'h0), .field(f_aux), .placed());
  dcr_field #(.MSB(CYL_MSB), .W(CYL_W)) u_cyl (.word(req.acc), .value(10'h000), .field(f_cyl), .placed());
  dcr_field #(.MSB(SURF_MSB), .W(SURF_W)) u_surf (.word(req.acc), .value(surf_q), .field(f_surf),
    .placed(p_surf));
  dcr_field #(.MSB(SECT_MSB), .W(SECT_W)) u_sect (.word(req.acc), .value(sect_q), .field(f_sect),
    .placed(p_sect));
  dcr_field #(.MSB(CNT_MSB), .W(CNT_W)) u_cnt (.word(req.acc), .value(cnt_q), .field(f_cnt),
    .placed(p_cnt));
  dcr_field #(.MSB(XMA_MSB), .W(AUX_W)) u_xma (.word(req.acc), .value(xma_q), .field(), .placed(p_xma));

  // ==========================================================
  // data-out a: command, drive, volume, pending page
  logic [3:0] cmd_q;
  logic [1:0] drv_q;
  logic vol_q;
  logic [3:0] aux_q;
  logic do_a;
  logic do_b;
  logic do_c;
  assign do_a = hit && (req.op == DCR_OP_DOA);
  assign do_b = hit && (req.op == DCR_OP_DOB);
  assign do_c = hit && (req.op == DCR_OP_DOC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= 4'h0;
      drv_q <= 2'h0;
      aux_q <= 4'h0;
    end else if (do_a) begin
      cmd_q <= f_cmd;
      drv_q <= f_drv;
      aux_q <= f_aux;
    end
  end

  // volume applies only to drives strapped as fixed/removable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_q <= 1'b0;
    end else if (do_a && drives_sync[f_drv]) begin
      vol_q <= req.acc[15-VOL_BIT];
    end
  end

  // one-hot decode of all sixteen codes
  always_comb begin
    cmd_decode = 16'h0000;
    cmd_decode[cmd_q] = 1'b1;
  end

  // ==========================================================
  // data-out b: memory pointer and page transfer
  logic [15:0] mem_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= 16'h0000;
      xma_q <= 4'h0;
    end else if (do_b) begin
      mem_q <= req.acc;
      xma_q <= aux_q;
    end
  end

  // ==========================================================
  // data-out c: disc address, meaning depends on last command
  logic [9:0] cyl_q;
  logic last_seek;
  assign last_seek = (cmd_q == SEEK_CODE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyl_q <= 10'h000;
    end else if (do_c && last_seek) begin
      cyl_q <= f_cyl;
    end
  end

  // sector field bits 6-10 follow head field bits 1-5, so the two loads share no bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      surf_q <= 5'h00;
      sect_q <= 5'h00;
      cnt_q <= 5'h00;
    end else if (do_c && !last_seek) begin
      surf_q <= f_surf;
      sect_q <= f_sect;
      cnt_q <= f_cnt;
    end
  end

  // ==========================================================
  // read-mode state
  dcr_mode_type mode_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= DCR_MODE_NORMAL;
    end else if (read_mode_load) begin
      mode_q <= read_mode_in;
    end
  end

  // ==========================================================
  // instruction class decode, shared by the valid flag and the checks
  function automatic logic is_read(input dcr_op_type op);
    is_read = (op == DCR_OP_DIA) || (op == DCR_OP_DIB) || (op == DCR_OP_DIC);
  endfunction

  // ==========================================================
  // data-in multiplexer, registered
  logic [15:0] rd_d;
  logic [15:0] rd_q;
  logic rv_q;
  always_comb begin
    rd_d = ZERO_WORD;
    case (req.op)
      DCR_OP_DIA: begin
        case (mode_q)
          DCR_MODE_ALT1: rd_d = mem_q;
          DCR_MODE_ALT2: rd_d = stat_sync.ecc[31:16];
          default: rd_d = {1'b0, stat_sync.cstat};
        endcase
      end
      DCR_OP_DIB: begin
        case (mode_q)
          DCR_MODE_ALT1: rd_d = p_xma;
          DCR_MODE_ALT2: rd_d = stat_sync.ecc[15:0];
          default: rd_d = {6'h00, stat_sync.dstat};
        endcase
      end
      DCR_OP_DIC: rd_d = p_surf | p_sect | p_cnt;
      default: rd_d = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 16'h0000;
      rv_q <= 1'b0;
    end else begin
      rv_q <= hit && is_read(req.op);
      if (hit) begin
        rd_q <= rd_d;
      end
    end
  end

  assign data_in_word = rd_q;
  assign data_in_valid = rv_q;
  assign command_code = cmd_q;
  assign drive_select = drv_q;
  assign host_memory_pointer = mem_q;
  assign extended_memory_page = xma_q;
  assign cylinder_number = cyl_q;
  assign volume_select = vol_q;
  assign head_number = surf_q;
  assign sector_number = sect_q;
  assign sector_count_neg = cnt_q;
  assign aux_dbg = {12'h000, aux_q};

  // ==========================================================
  // checks
  chk_cmd_load: assert property (@(posedge clk) disable iff (!rst_n)
    do_a |=> command_code == $past(req.acc[10:7])) else $error("command not loaded");
  chk_drv_load: assert property (@(posedge clk) disable iff (!rst_n)
    do_a |=> drive_select == $past(req.acc[6:5])) else $error("drive not loaded");
  chk_mem_load: assert property (@(posedge clk) disable iff (!rst_n)
    do_b |=> host_memory_pointer == $past(req.acc)) else $error("pointer not loaded");
  chk_page_copy: assert property (@(posedge clk) disable iff (!rst_n)
    do_a ##1 (do_b && !do_a) |=> extended_memory_page == $past(req.acc[3:0], 2))
    else $error("page not copied");
  chk_cyl_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && !last_seek) |=> $stable(cylinder_number)) else $error("cylinder changed");
  chk_cnt_load: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && !last_seek) |=> sector_count_neg == $past(req.acc[4:0])) else $error("count wrong");
  chk_head_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && last_seek) |=> $stable(head_number)) else $error("head changed");
  chk_dev_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    (req.strobe && req.devcode != devcode_q) |=> !data_in_valid) else $error("foreign code");
  chk_dic_read: assert property (@(posedge clk) disable iff (!rst_n)
    (hit && req.op == DCR_OP_DIC) |=> data_in_word[4:0] == sector_count_neg) else $error("dic wrong");
  chk_vol_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (do_a && !drives_sync[f_drv]) |=> $stable(volume_select)) else $error("volume changed");
  chk_rd_valid: assert property (@(posedge clk) disable iff (!rst_n)
    (hit && is_read(req.op)) |=> data_in_valid) else $error("read not answered");
  chk_wr_novalid: assert property (@(posedge clk) disable iff (!rst_n)
    (hit && !is_read(req.op)) |=> !data_in_valid) else $error("write answered");
  chk_decode_hot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(cmd_decode) && cmd_decode[command_code]) else $error("decode not one-hot");
  chk_cyl_load: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && last_seek) |=> cylinder_number == $past(req.acc[9:0])) else $error("cylinder wrong");
  chk_head_load: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && !last_seek) |=> head_number == $past(req.acc[14:10])) else $error("head wrong");
  chk_sect_load: assert property (@(posedge clk) disable iff (!rst_n)
    (do_c && !last_seek) |=> sector_number == $past(req.acc[9:5])) else $error("sector wrong");
  chk_vol_load: assert property (@(posedge clk) disable iff (!rst_n)
    (do_a && drives_sync[f_drv]) |=> volume_select == $past(req.acc[4])) else $error("volume wrong");
  chk_aux_load: assert property (@(posedge clk) disable iff (!rst_n)
    do_a |=> aux_dbg[3:0] == $past(req.acc[3:0])) else $error("pending page wrong");
  chk_ecc_high: assert property (@(posedge clk) disable iff (!rst_n)
    (hit && req.op == DCR_OP_DIA && mode_q == DCR_MODE_ALT2) |=> data_in_word == $past(stat_sync.ecc[31:16]))
    else $error("ecc high wrong");
  chk_ecc_low: assert property (@(posedge clk) disable iff (!rst_n)
    (hit && req.op == DCR_OP_DIB && mode_q == DCR_MODE_ALT2) |=> data_in_word == $past(stat_sync.ecc[15:0]))
    else $error("ecc low wrong");
  chk_mode_load: assert property (@(posedge clk) disable iff (!rst_n)
    read_mode_load |=> mode_q == $past(read_mode_in)) else $error("mode not loaded");
  chk_strap_take: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(strap_done_q) |-> devcode_q == $past(devcode_strap)) else $error("strap not taken");
  chk_rd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !hit |=> $stable(data_in_word)) else $error("read word moved");
  chk_page_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !do_b |=> $stable(extended_memory_page)) else $error("page moved");
  chk_ptr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !do_b |=> $stable(host_memory_pointer)) else $error("pointer moved");
  chk_cnt_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(do_c && !last_seek) |=> $stable(sector_count_neg)) else $error("count moved");
endmodule

// ===== sim/dcr_host.sv
// processor-side model that issues programmed i/o instructions to the bank
`timescale 1ns/1ps
module dcr_host
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] data_in_word,
  input wire logic data_in_valid,
  output dcr_req_type req
);
  initial req = '{strobe: 1'b0, op: DCR_OP_NONE, devcode: 6'h00, acc: 16'hffff};

  // ==========================================================
  // one instruction: strobe held for one edge, answer sampled one cycle on
  task automatic io(input dcr_op_type op, input logic [5:0] dev, input logic [15:0] acc,
                    output logic [15:0] rd, output logic vld);
    @(posedge clk);
    req <= '{strobe: 1'b1, op: op, devcode: dev, acc: acc};
    @(posedge clk);
    // released bus must not look like the last word
    req <= '{strobe: 1'b0, op: DCR_OP_NONE, devcode: ~dev, acc: ~acc};
    #1;
    rd = data_in_word;
    vld = data_in_valid;
  endtask

  // two instructions on consecutive edges, with no idle cycle between them
  task automatic io_pair(input dcr_op_type op1, input logic [15:0] acc1, input dcr_op_type op2,
                         input logic [15:0] acc2, input logic [5:0] dev);
    @(posedge clk);
    req <= '{strobe: 1'b1, op: op1, devcode: dev, acc: acc1};
    @(posedge clk);
    req <= '{strobe: 1'b1, op: op2, devcode: dev, acc: acc2};
    @(posedge clk);
    req <= '{strobe: 1'b0, op: DCR_OP_NONE, devcode: ~dev, acc: ~acc2};
    #1;
  endtask
endmodule

// ===== sim/tb_dcr_regs.sv
// self-checking bench for the disc controller register bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dcr_regs
  import dcr_pkg::*;
;
  typedef struct packed {
    dcr_op_type op;
    dcr_mode_type mode;
    logic [15:0] acc;
    logic [15:0] exp;
  } dcr_row_type;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dcr_req_type req;
  logic [3:0] fixed_removable_drives = 4'h4;
  logic [5:0] devcode_strap = DEVCODE_RST;
  dcr_mode_type read_mode_in = DCR_MODE_NORMAL;
  logic read_mode_load = 1'b0;
  dcr_status_type status_in = '{ecc: 32'h89abcdef, cstat: 15'h5a5a, dstat: 10'h2c3};
  logic [15:0] data_in_word, cmd_decode, host_memory_pointer, aux_dbg, rd;
  logic data_in_valid, volume_select, vld;
  logic [3:0] command_code, extended_memory_page;
  logic [1:0] drive_select;
  logic [9:0] cylinder_number;
  logic [4:0] head_number, sector_number, sector_count_neg;
  int num_errors = 0;
  int total_checks = 0;
  dcr_row_type rows [11];

  always #12.5 clk = ~clk;

  dcr_host i_dcr_host (.clk(clk), .data_in_word(data_in_word), .data_in_valid(data_in_valid), .req(req));

  dcr_regs i_dcr_regs (.clk(clk), .rst_n(rst_n), .req(req), .devcode_strap(devcode_strap),
    .fixed_removable_drives(fixed_removable_drives), .read_mode_in(read_mode_in),
    .read_mode_load(read_mode_load), .status_in(status_in), .data_in_word(data_in_word),
    .data_in_valid(data_in_valid), .cmd_decode(cmd_decode), .command_code(command_code),
    .drive_select(drive_select), .host_memory_pointer(host_memory_pointer),
    .extended_memory_page(extended_memory_page), .cylinder_number(cylinder_number),
    .volume_select(volume_select), .head_number(head_number), .sector_number(sector_number),
    .sector_count_neg(sector_count_neg), .aux_dbg(aux_dbg));

  // ==========================================================
  function automatic logic [15:0] view(dcr_op_type op);
    case (op)
      DCR_OP_DOA: view = {5'h00, command_code, drive_select, volume_select, aux_dbg[3:0]};
      DCR_OP_DOB: view = host_memory_pointer;
      DCR_OP_DOC: view = {1'b0, head_number, sector_number, sector_count_neg};
      default: view = rd;
    endcase
  endfunction

  task automatic set_mode(input dcr_mode_type m);
    @(posedge clk);
    read_mode_in <= m;
    read_mode_load <= 1'b1;
    @(posedge clk);
    read_mode_load <= 1'b0;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole run is far below this bound
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    // drive 2 is fixed/removable, drive 1 is not, so its volume bit is dropped
    rows = '{'{DCR_OP_DOA, DCR_MODE_NORMAL, 16'h02da, 16'h02da},
             '{DCR_OP_DOA, DCR_MODE_NORMAL, 16'h07a3, 16'h07b3},
             '{DCR_OP_DOB, DCR_MODE_NORMAL, 16'h1234, 16'h1234},
             '{DCR_OP_DOC, DCR_MODE_NORMAL, 16'h555d, 16'h555d},
             '{DCR_OP_DIA, DCR_MODE_NORMAL, 16'h0000, 16'h5a5a},
             '{DCR_OP_DIB, DCR_MODE_NORMAL, 16'h0000, 16'h02c3},
             '{DCR_OP_DIC, DCR_MODE_NORMAL, 16'h0000, 16'h555d},
             '{DCR_OP_DIA, DCR_MODE_ALT1, 16'h0000, 16'h1234},
             '{DCR_OP_DIB, DCR_MODE_ALT1, 16'h0000, 16'h0003},
             '{DCR_OP_DIA, DCR_MODE_ALT2, 16'h0000, 16'h89ab},
             '{DCR_OP_DIB, DCR_MODE_ALT2, 16'h0000, 16'hcdef}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      set_mode(rows[i].mode);
      i_dcr_host.io(rows[i].op, DEVCODE_RST, rows[i].acc, rd, vld);
      `CHK(view(rows[i].op), rows[i].exp)
      `CHK(vld, (rows[i].op >= DCR_OP_DIA))
    end
    $display("test table done");
    for (int k = 0; k < 16; k++) begin
      i_dcr_host.io(DCR_OP_DOA, DEVCODE_RST, {5'h00, k[3:0], 7'h00}, rd, vld);
      `CHK(command_code, k[3:0])
      `CHK(cmd_decode, 16'h0001 << k)
    end
    $display("test commands done");
    i_dcr_host.io(DCR_OP_DOA, DEVCODE_RST, 16'h0100, rd, vld);
    i_dcr_host.io(DCR_OP_DOC, DEVCODE_RST, 16'hfea5, rd, vld);
    `CHK(cylinder_number, 10'h2a5)
    `CHK(view(DCR_OP_DOC), 16'h555d)
    $display("test seek done");
    i_dcr_host.io(DCR_OP_DOB, 6'h16, 16'hffff, rd, vld);
    `CHK(host_memory_pointer, 16'h1234)
    i_dcr_host.io(DCR_OP_DIA, 6'h16, 16'h0000, rd, vld);
    `CHK(vld, 1'b0)
    $display("test foreign code done");
    i_dcr_host.io_pair(DCR_OP_DOA, 16'h0405, DCR_OP_DOB, 16'h4321, DEVCODE_RST);
    `CHK(extended_memory_page, 4'h5)
    `CHK(host_memory_pointer, 16'h4321)
    $display("test back to back done");
    @(posedge clk);
    rst_n <= 1'b0;
    devcode_strap <= 6'h21;
    repeat (2) @(posedge clk);
    `CHK(view(DCR_OP_DOA), 16'h0000)
    `CHK(cmd_decode, 16'h0001)
    `CHK(host_memory_pointer, 16'h0000)
    rst_n <= 1'b1;
    // status pins need four edges through the synchroniser
    repeat (4) @(posedge clk);
    i_dcr_host.io(DCR_OP_DIA, 6'h21, 16'h0000, rd, vld);
    `CHK(rd, 16'h5a5a)
    i_dcr_host.io(DCR_OP_DIA, DEVCODE_RST, 16'h0000, rd, vld);
    `CHK(vld, 1'b0)
    $display("test reset done");
    end_sim();
  end
endmodule
